// ---- rtl/flash_command_timing_security.sv ----
// flash command timing, security state and option loading behind an AXI4-Lite slave
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.svh"
module flash_command_timing_security
  import flash_seq_pkg::*;
#(
  parameter logic [`TICK_W-1:0] PAGE_ERASE_TICKS = `PAGE_ERASE_TICKS,
  parameter logic [`TICK_W-1:0] MASS_ERASE_TICKS = `MASS_ERASE_TICKS
)
(
  input  wire logic               CLK,
  input  wire logic               RST_B,
  input  wire logic [`AXI_AW-1:0] S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic [1:0]              S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [`AXI_AW-1:0] S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic [31:0]             S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY,
  input  wire logic [7:0]         NV_PROT,
  input  wire logic [7:0]         NV_OPT,
  input  wire logic [63:0]        NV_KEY,
  input  wire logic               FLASH_BLANK,
  output flash_op_s               FLASH_OP,
  output logic                    IRQ
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic reg_e decode_reg(input logic [`AXI_AW-1:0] a);
    if (a[7:5] == 3'b010 && a[1:0] == 2'b00)
      return REG_KEY;
    case (a)
      `OFS_DIVIDER:  return REG_DIV;
      `OFS_CONFIG:   return REG_CFG;
      `OFS_STATUS:   return REG_STAT;
      `OFS_MASK:     return REG_MASK;
      `OFS_SECURITY: return REG_SEC;
      `OFS_PROT:     return REG_PROT;
      `OFS_OPT:      return REG_OPT;
      `OFS_CMD_ADDR: return REG_CADDR;
      `OFS_CMD_DATA: return REG_CDATA;
      `OFS_CMD:      return REG_CMD;
      default:       return REG_NONE;
    endcase
  endfunction : decode_reg

  // ****************************************************************
  // state
  // ****************************************************************
  state_e              state;
  flash_op_s           op_q;
  logic                aw_held;
  logic                w_held;
  logic [`AXI_AW-1:0]  aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic [`DIV_W-1:0]   divider;
  logic                div_loaded;
  logic [2:0]          cfg;
  logic [`STAT_W-1:0]  status;
  logic [`STAT_W-1:0]  mask;
  logic [1:0]          sec;
  logic [7:0]          prot;
  logic [7:0]          opt;
  logic [15:0]         cmd_addr;
  logic [7:0]          cmd_data;
  logic                burst_active;
  logic [7:0]          key_byte [`KEY_BYTES];
  logic [`KEY_BYTES-1:0] key_written;
  logic [`KEY_BYTES-1:0] key_match;
  logic                tick;
  logic                timer_busy;
  logic                timer_done;

  // ****************************************************************
  // write path decode
  // ****************************************************************
  wire       wr_fire   = aw_held && w_held && !S_AXI_BVALID;
  reg_e      wsel;
  assign     wsel      = decode_reg(aw_addr);
  wire       we        = wr_fire && w_strb[0] && (wsel != REG_NONE);
  wire [7:0] wbyte     = w_data[7:0];
  wire [2:0] key_idx   = aw_addr[4:2];
  wire       key_access_enable    = cfg[`KEY_ACCESS_ENABLE_BIT - `CFG_LSB];
  wire       acc_err   = status[`STAT_ACCERR];

  // write-once, and not while the access error flag stands
  wire div_we  = we && (wsel == REG_DIV) && !div_loaded && !acc_err;
  // key range write steers to command or compare by key access bit
  wire key_cmd = we && (wsel == REG_KEY) && !key_access_enable;
  wire key_we  = we && (wsel == REG_KEY) && key_access_enable;
  wire cmd_req = (we && (wsel == REG_CMD)) || key_cmd;

  cmd_e req_op;
  assign req_op = key_cmd ? CMD_BYTE_PROG : cmd_e'(wbyte[2:0]);
  wire [15:0] req_addr = key_cmd ? (`KEY_RANGE_BASE | {13'h0000, key_idx}) : cmd_addr;
  wire [7:0]  req_data = key_cmd ? wbyte : cmd_data;
  wire        op_legal = (req_op != CMD_NONE) && (req_op <= CMD_BLANK_CHECK);

  // no command before the divider is written, nor while one runs
  wire cmd_ok  = cmd_req && div_loaded && (state == ST_IDLE) && op_legal;
  wire cmd_bad = cmd_req && !cmd_ok;

  // per-command length in timing clock periods
  wire [`TICK_W-1:0] start_ticks =
      (req_op == CMD_PAGE_ERASE)  ? PAGE_ERASE_TICKS :
      (req_op == CMD_MASS_ERASE)  ? MASS_ERASE_TICKS :
      (req_op == CMD_BLANK_CHECK) ? `BLANK_CHECK_TICKS :
      (req_op == CMD_BURST_PROG && burst_active) ? `BURST_PROG_TICKS :
      `BYTE_PROG_TICKS;

  // ****************************************************************
  // events and interrupt
  // ****************************************************************
  wire key_all     = &key_written;
  wire key_ok_ev   = key_all && (&key_match);
  wire key_fail_ev = key_all && !(&key_match);
  wire blank_ok    = timer_done && (op_q.op == CMD_BLANK_CHECK) && FLASH_BLANK;

  wire [`STAT_W-1:0] stat_set = {key_fail_ev, key_ok_ev, cmd_bad, timer_done};
  wire [`STAT_W-1:0] stat_clr = (we && wsel == REG_STAT) ? wbyte[`STAT_W-1:0] : '0;
  // a new event wins over a clear in the same cycle
  wire [`STAT_W-1:0] next_status = (status & ~stat_clr) | stat_set;

  assign IRQ = |(status & mask);

  // ****************************************************************
  // AXI4-Lite write channels
  // ****************************************************************
  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY  = !w_held;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && !w_held) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (wsel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channels
  // ****************************************************************
  reg_e rsel;
  assign rsel = decode_reg(S_AXI_ARADDR);
  // key bytes never read back, so a secured part cannot leak them
  wire [31:0] rd_word =
      (rsel == REG_DIV)   ? {div_loaded, 20'h0_0000, divider} :
      (rsel == REG_CFG)   ? {24'h00_0000, cfg, 5'h00} :
      (rsel == REG_STAT)  ? {24'h00_0000, timer_busy, 3'h0, status} :
      (rsel == REG_MASK)  ? {28'h000_0000, mask} :
      (rsel == REG_SEC)   ? {29'h0000_0000, (sec == `SEC_UNSECURED), sec} :
      (rsel == REG_PROT)  ? {24'h00_0000, prot} :
      (rsel == REG_OPT)   ? {24'h00_0000, opt} :
      (rsel == REG_CADDR) ? {16'h0000, cmd_addr} :
      (rsel == REG_CDATA) ? {24'h00_0000, cmd_data} :
      (rsel == REG_CMD)   ? {29'h0000_0000, op_q.op} :
      32'h0000_0000;

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_word;
      S_AXI_RRESP  <= (rsel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      divider    <= `DIV_RESET;
      div_loaded <= 1'b0;
    end else if (div_we) begin
      divider    <= w_data[`DIV_W-1:0];
      div_loaded <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg      <= 3'h0;
      mask     <= '0;
      status   <= '0;
      cmd_addr <= 16'h0000;
      cmd_data <= 8'h00;
    end else begin
      status <= next_status;
      if (we && wsel == REG_CFG)
        cfg <= wbyte[7:`CFG_LSB];
      if (we && wsel == REG_MASK)
        mask <= wbyte[`STAT_W-1:0];
      if (we && wsel == REG_CADDR)
        cmd_addr <= w_data[15:0];
      if (we && wsel == REG_CDATA)
        cmd_data <= wbyte;
    end
  end

  // ****************************************************************
  // stored option load and security
  // ****************************************************************
  // stored bytes caught in the first cycle after reset release
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prot <= 8'h00;
      opt  <= 8'h00;
      sec  <= `SEC_RESET;
    end else if (state == ST_LOAD) begin
      prot <= NV_PROT;
      opt  <= NV_OPT;
      sec  <= NV_OPT[1:0];
    end else if (key_ok_ev || blank_ok) begin
      sec  <= `SEC_UNSECURED;
    end
  end

  // ****************************************************************
  // backdoor key compare
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < `KEY_BYTES; i++) begin : g_key
      wire hit = key_we && (key_idx == 3'(i));
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          key_byte[i]    <= 8'h00;
          key_written[i] <= 1'b0;
          key_match[i]   <= 1'b0;
        end else begin
          if (state == ST_LOAD)
            key_byte[i] <= NV_KEY[8*i +: 8];
          if (hit) begin
            key_written[i] <= 1'b1;
            key_match[i]   <= (wbyte == key_byte[i]);
          end else if (key_all) begin
            key_written[i] <= 1'b0;
            key_match[i]   <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  state_e    next_state;
  flash_op_s next_op;

  always_comb begin
    next_state = state;
    next_op    = op_q;
    case (state)
      ST_LOAD: begin
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (cmd_ok) begin
          next_state   = ST_BUSY;
          next_op.op   = req_op;
          next_op.addr = req_addr;
          next_op.page = req_addr[15:`PAGE_SHIFT];
          next_op.data = req_data;
          next_op.hv   = 1'b1;
        end
      end
      ST_BUSY: begin
        if (timer_done) begin
          next_state = ST_IDLE;
          next_op    = '0;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_op    = '0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state        <= ST_LOAD;
      op_q         <= '0;
      burst_active <= 1'b0;
    end else begin
      state <= next_state;
      op_q  <= next_op;
      if (cmd_ok)
        burst_active <= burst_active && (req_op == CMD_BURST_PROG);
      else if (timer_done && op_q.op == CMD_BURST_PROG)
        burst_active <= 1'b1;
    end
  end

  assign FLASH_OP = op_q;

  // ****************************************************************
  // timing clock and pulse timer
  // ****************************************************************
  flash_timing_clock_tick_gen u_tick (
    .clk     (CLK),
    .rst_b   (RST_B),
    .enable  (div_loaded),
    .restart (cmd_ok),
    .divisor (divider),
    .tick    (tick)
  );

  tick_timer u_timer (
    .clk   (CLK),
    .rst_b (RST_B),
    .start (cmd_ok),
    .ticks (start_ticks),
    .tick  (tick),
    .busy  (timer_busy),
    .done  (timer_done)
  );

endmodule : flash_command_timing_security
`default_nettype wire

// ---- common/flash_seq_defines.svh ----
// register map, field positions, reset values and tick counts of the flash sequencer
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define AXI_AW            8
`define OFS_DIVIDER       8'h00
`define OFS_CONFIG        8'h04
`define OFS_STATUS        8'h08
`define OFS_MASK          8'h0C
`define OFS_SECURITY      8'h10
`define OFS_PROT          8'h14
`define OFS_OPT           8'h18
`define OFS_CMD_ADDR      8'h1C
`define OFS_CMD_DATA      8'h20
`define OFS_CMD           8'h24
`define OFS_KEY_BASE      8'h40

// ****************************************************************
// fields and reset values
// ****************************************************************
`define DIV_W             11
`define DIV_LOADED_BIT    31
`define DIV_RESET         11'h000
`define CFG_LSB           5
`define KEY_ACCESS_ENABLE_BIT        5
`define STAT_DONE         0
`define STAT_ACCERR       1
`define STAT_KEY_OK       2
`define STAT_KEY_FAIL     3
`define STAT_BUSY         7
`define STAT_W            4
`define SEC_UNSECURED     2'b10
`define SEC_RESET         2'b11
`define KEY_BYTES         8
`define KEY_RANGE_BASE    16'hFFB0
`define PAGE_SHIFT        9
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

// ****************************************************************
// timing
// ****************************************************************
`define TICK_W            15
`define BYTE_PROG_TICKS   15'h0009
`define BURST_PROG_TICKS  15'h0004
`define PAGE_ERASE_TICKS  15'h0FA0
`define MASS_ERASE_TICKS  15'h4E20
`define BLANK_CHECK_TICKS 15'h0020
`define CLK_HZ            200000000
`define FLASH_TIMING_CLOCK_MIN_HZ       150000
`define FLASH_TIMING_CLOCK_MAX_HZ       200000
`define DIV_MIN           ((`CLK_HZ + `FLASH_TIMING_CLOCK_MAX_HZ - 1) / `FLASH_TIMING_CLOCK_MAX_HZ - 1)
`define DIV_MAX           (`CLK_HZ / `FLASH_TIMING_CLOCK_MIN_HZ - 1)

`endif

// ---- common/flash_seq_pkg.sv ----
// types shared by the flash sequencer modules
package flash_seq_pkg;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_BYTE_PROG,
    CMD_BURST_PROG,
    CMD_PAGE_ERASE,
    CMD_MASS_ERASE,
    CMD_BLANK_CHECK
  } cmd_e;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_IDLE,
    ST_BUSY
  } state_e;

  typedef enum logic [3:0] {
    REG_DIV, REG_CFG, REG_STAT, REG_MASK, REG_SEC, REG_PROT,
    REG_OPT, REG_CADDR, REG_CDATA, REG_CMD, REG_KEY, REG_NONE
  } reg_e;

  typedef struct packed {
    cmd_e        op;
    logic [15:0] addr;
    logic [6:0]  page;
    logic [7:0]  data;
    logic        hv;
  } flash_op_s;

endpackage : flash_seq_pkg

// ---- rtl/flash_timing_clock_tick_gen.sv ----
// divider that turns the bus clock into timing clock ticks
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.svh"
module flash_timing_clock_tick_gen
  import flash_seq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              enable,
  input  wire logic              restart,
  input  wire logic [`DIV_W-1:0] divisor,
  output logic                   tick
);

  logic [`DIV_W-1:0] count;
  wire               wrap = (count == divisor);

  // one tick every divisor+1 bus clocks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= (!enable || restart || wrap) ? '0 : count + 1'b1;
      tick  <= enable && !restart && wrap;
    end
  end

endmodule : flash_timing_clock_tick_gen
`default_nettype wire

// ---- rtl/tick_timer.sv ----
// counts a number of timing clock ticks and flags the end
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.svh"
module tick_timer
  import flash_seq_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               start,
  input  wire logic [`TICK_W-1:0] ticks,
  input  wire logic               tick,
  output logic                    busy,
  output logic                    done
);

  logic [`TICK_W-1:0] remaining;
  wire                last = busy && tick && (remaining == `TICK_W'(1));

  // whole periods only: the tick source restarts with start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      remaining <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= last;
      if (start) begin
        remaining <= ticks;
        busy      <= 1'b1;
      end else if (last) begin
        busy <= 1'b0;
      end else if (busy && tick) begin
        remaining <= remaining - 1'b1;
      end
    end
  end

endmodule : tick_timer
`default_nettype wire

// ---- testbench/flash_seq_chk.sv ----
// port assertions for the flash sequencer top module
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.svh"
module flash_seq_chk
  import flash_seq_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire flash_op_s   FLASH_OP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic busy;
  assign busy = FLASH_OP.op != CMD_NONE;

  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("read not answered");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID) else $error("write not answered");
  a_aw_blocked: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("address taken while one held");
  a_op_steady: assert property (busy |=> !busy || $stable(FLASH_OP))
    else $error("command changed mid run");
  a_op_hv: assert property (busy |-> FLASH_OP.hv)
    else $error("voltage off during command");
  a_idle_zero: assert property (!busy |-> FLASH_OP == '0)
    else $error("idle command not zero");
  a_page_field: assert property (busy |-> FLASH_OP.page == FLASH_OP.addr[15:`PAGE_SHIFT])
    else $error("page field wrong");
  a_min_pulse: assert property ($rose(busy) |-> busy[*4])
    else $error("command too short");
endmodule : flash_seq_chk
`default_nettype wire

// ---- testbench/flash_array_model.sv ----
// behavioural flash array: measures command length, tracks blank state
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
  import flash_seq_pkg::*;
(
  input  wire logic      clk,
  input  wire flash_op_s op,
  output logic           blank,
  output logic [15:0]    len
);
  logic [15:0] cnt = 16'h0000;
  cmd_e        last = CMD_NONE;
  initial blank = 1'b0;
  initial len = 16'h0000;
  always @(posedge clk) begin
    if (op.op != CMD_NONE) begin
      cnt <= cnt + 16'h0001;
      last <= op.op;
    end else if (cnt != 16'h0000) begin
      len <= cnt;
      cnt <= 16'h0000;
      // mass-erased array reads blank until the next program
      if (last == CMD_MASS_ERASE) blank <= 1'b1;
      else if (last == CMD_BYTE_PROG || last == CMD_BURST_PROG) blank <= 1'b0;
    end
  end
endmodule : flash_array_model
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb;
  import flash_seq_pkg::*;
  // 1000 bus clocks a tick keeps the timing clock at 200 kHz
  localparam logic [10:0] DIV = 11'h3E7;
  // short erases so the run stays inside its cycle budget
  localparam logic [14:0] PE = 15'h0008;
  localparam logic [14:0] ME = 15'h000C;
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_s;
  typedef struct {cmd_e op; logic [14:0] n;} cmd_s;
  logic clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq, blank, ok;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] len, lo;
  flash_op_s flash_op;
  int fails = 0, checks = 0;
  row_s rows[8] = '{'{0, 8'h00, 0, 0, 2'b00}, '{1, 8'h04, 32'h0000_00FF, 32'h0000_00E0, 2'b00},
    '{1, 8'h04, 0, 0, 2'b00}, '{0, 8'h10, 0, 1, 2'b00}, '{0, 8'h14, 0, 32'h0000_003A, 2'b00},
    '{0, 8'h18, 0, 32'h0000_00C5, 2'b00}, '{1, 8'h18, 0, 32'h0000_00C5, 2'b00},
    '{1, 8'h30, 32'h0000_0055, 0, 2'b10}};
  cmd_s cmds[6] = '{'{CMD_BYTE_PROG, 9}, '{CMD_BURST_PROG, 9}, '{CMD_BURST_PROG, 4},
    '{CMD_PAGE_ERASE, PE}, '{CMD_MASS_ERASE, ME}, '{CMD_BLANK_CHECK, 32}};

  flash_command_timing_security #(.PAGE_ERASE_TICKS(PE), .MASS_ERASE_TICKS(ME)) dut_u (
    .CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .NV_PROT(8'h3A), .NV_OPT(8'hC5), .NV_KEY(KEY), .FLASH_BLANK(blank), .FLASH_OP(flash_op),
    .IRQ(irq));
  flash_array_model array_u (.clk(clk), .op(flash_op), .blank(blank), .len(len));

  always #2.5 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic timeout();
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    stop_test();
  endtask : timeout

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (n == 64) timeout();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rsp = rresp;
    if (n == 64) timeout();
    else `CHK(rdata, e)
  endtask : rd

  task automatic wait_idle();
    int n;
    for (n = 0; n < 40000 && flash_op.op != CMD_NONE; n++) @(posedge clk);
    if (n == 40000) timeout();
    else repeat (2) @(posedge clk);
  endtask : wait_idle

  task automatic keys(input logic [7:0] x);
    for (int i = 0; i < 8; i++) wr(8'(`OFS_KEY_BASE + 4 * i), {24'h0, KEY[8*i+:8] ^ (i == 7 ? x : 8'h00)});
  endtask : keys

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        `CHK(rsp, rows[i].r)
      end
      rd(rows[i].a, rows[i].e);
      `CHK(rsp, rows[i].r)
    end
    wstrb <= 4'h0;
    wr(`OFS_MASK, 32'h0000_000F);
    wstrb <= 4'hF;
    rd(`OFS_MASK, 32'h0000_0000);
    $display("test registers done");
    wr(`OFS_CMD, 32'h0000_0001);
    rd(`OFS_STATUS, 32'h0000_0002);
    `CHK(flash_op.op, CMD_NONE)
    wr(`OFS_MASK, 32'h0000_0002);
    `CHK(irq, 1'b1)
    wr(`OFS_DIVIDER, {21'h0, DIV});
    rd(`OFS_DIVIDER, 32'h0000_0000);
    wr(`OFS_MASK, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(`OFS_STATUS, 32'h0000_0002);
    rd(`OFS_STATUS, 32'h0000_0000);
    wr(`OFS_DIVIDER, {21'h0, DIV});
    rd(`OFS_DIVIDER, {21'h10_0000, DIV});
    wr(`OFS_DIVIDER, 32'h0000_0005);
    rd(`OFS_DIVIDER, {21'h10_0000, DIV});
    $display("test divider done");
    wr(`OFS_CMD_ADDR, 32'h0000_1234);
    wr(`OFS_CMD_DATA, 32'h0000_00A5);
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_CMD, {29'h0, cmds[i].op});
      `CHK(flash_op.op, cmds[i].op)
      `CHK(flash_op.page, 7'h09)
      wait_idle();
      lo = 16'(cmds[i].n) * (16'(DIV) + 16'h0001);
      ok = len >= lo && len <= lo + 16'h0003;
      `CHK(ok, 1'b1)
      rd(`OFS_STATUS, 32'h0000_0001);
      wr(`OFS_STATUS, 32'h0000_000F);
    end
    rd(`OFS_SECURITY, 32'h0000_0006);
    wr(`OFS_CMD, 32'h0000_0007);
    rd(`OFS_STATUS, 32'h0000_0002);
    wr(`OFS_STATUS, 32'h0000_000F);
    wr(8'h4C, 32'h0000_0077);
    `CHK(flash_op.addr, 16'hFFB3)
    `CHK(flash_op.data, 8'h77)
    wait_idle();
    $display("test commands done");
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(`OFS_SECURITY, 32'h0000_0001);
    rd(`OFS_DIVIDER, 32'h0000_0000);
    wr(`OFS_CONFIG, 32'h0000_0020);
    keys(8'h01);
    `CHK(flash_op.op, CMD_NONE)
    rd(`OFS_STATUS, 32'h0000_0008);
    rd(`OFS_SECURITY, 32'h0000_0001);
    wr(`OFS_STATUS, 32'h0000_000F);
    keys(8'h00);
    rd(`OFS_STATUS, 32'h0000_0004);
    rd(`OFS_SECURITY, 32'h0000_0006);
    $display("test keys done");
    stop_test();
  end
endmodule : tb

bind flash_command_timing_security flash_seq_chk chk_u (.CLK, .RST_B, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .FLASH_OP);
`default_nettype wire
